// >>> logic/pcr_pkg.sv
package pcr_pkg;
    localparam logic [7:0] PWR_CTRL_ADDR = 8'h87;
    localparam logic [7:0] SUP_MON_CTRL_ADDR = 8'hFF;
    localparam logic [7:0] RST_CAUSE_ADDR = 8'hEF;
    localparam int PC_IDLE_BIT = 0;
    localparam int PC_STOP_BIT = 1;
    localparam int PC_FLAG_LSB = 2;
    localparam int PC_FLAG_W = 6;
    localparam int SMC_EN_BIT = 7;
    localparam int SMC_STAT_BIT = 6;
    localparam int SMC_LVL_BIT = 5;
    localparam int RC_POR_BIT = 1;
    localparam logic [5:0] FLAGS_RESET = 6'h00;
    localparam logic [7:0] RDATA_ZERO = 8'h00;
    localparam logic [7:0] PORT_LATCH_RESET = 8'hFF;
    localparam logic [15:0] RESET_VECTOR = 16'h0000;
    localparam logic [3:0] WDT_DIV = 4'hC;
    localparam int CLK_PERIOD_NS = 8;
    localparam int POR_DELAY_NS = 100000;
    localparam int POR_DELAY_CYC =
        (POR_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    typedef enum logic [1:0] {
        ST_POR_HOLD,
        ST_POR_DELAY,
        ST_RESET_HOLD,
        ST_RUN
    } pcr_state_t;
endpackage

// >>> logic/pcr_delay_counter.sv
`timescale 1ns/10ps
module pcr_delay_counter #(
    parameter int CNT_W = 20,
    parameter int COUNT = 12500
) (
    input wire logic clock_i,  // system clock
    input wire logic arst_n_i, // async reset, active low
    input wire logic run_i,    // count while high, clear when low
    output logic done_o        // high once COUNT cycles have run
);
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic done;
    logic next_done;

    initial begin
        if (COUNT < 1 || COUNT >= (2 ** CNT_W)) begin
            $error("pcr_delay_counter: COUNT does not fit CNT_W");
        end
    end

    always_comb begin
        next_cnt = cnt;
        next_done = 1'b0;
        if (!run_i) begin
            next_cnt = '0;
        end else if (cnt != CNT_W'(COUNT - 1)) begin
            next_cnt = cnt + CNT_W'(1);
        end else begin
            next_done = 1'b1;
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt <= '0;
            done <= 1'b0;
        end else begin
            cnt <= next_cnt;
            done <= next_done;
        end
    end

    assign done_o = done;
endmodule // pcr_delay_counter

// >>> logic/pcr_power_reset.sv
`timescale 1ns/10ps
module pcr_power_reset
    import pcr_pkg::*;
#(
    parameter int POR_DELAY_CYCLES = POR_DELAY_CYC
) (
    input wire logic clock_i,          // system clock, 125 MHz
    input wire logic arst_n_i,         // async reset, active low
    input wire logic [7:0] sfr_addr_i, // register address
    input wire logic [7:0] sfr_wdata_i,// write data
    input wire logic sfr_wr_i,         // write strobe
    input wire logic sfr_rd_i,         // read strobe
    output logic [7:0] sfr_rdata_o,    // read data, one cycle later
    input wire logic power_on_i,       // power-on detector active
    input wire logic supply_above_i,   // monitor comparator: supply ok
    input wire logic flash_op_i,       // flash erase or write attempt pulse
    input wire logic sw_reset_i,       // software reset request pulse
    input wire logic wdt_reset_i,      // watchdog timeout pulse
    input wire logic wdt_disable_i,    // software disables watchdog
    input wire logic irq_pending_i,    // an enabled interrupt asserted
    input wire logic rst_pin_i,        // reset pin level (unused by logic)
    output logic rst_pin_o,            // reset pin output level (low)
    output logic rst_pin_oe_o,         // reset pin driven
    output logic core_reset_o,         // core held in reset
    output logic boot_o,               // one-cycle pulse at reset exit
    output logic [15:0] fetch_addr_o,  // first fetch address
    output logic clk_sel_internal_o,   // force internal oscillator
    output logic cpu_clk_en_o,         // cpu clock enable
    output logic periph_clk_en_o,      // peripheral clock enable
    output logic osc_stop_o,           // internal oscillator halted
    output logic port_force_o,         // ports forced to reset state
    output logic [7:0] port_latch_o,   // port latch reset value
    output logic weak_pullup_en_o,     // weak pull-ups enabled
    output logic wdt_enable_o,         // watchdog running
    output logic wdt_tick_o            // watchdog clock, sysclk/12
);
    initial begin
        if (POR_DELAY_CYCLES < 1 || POR_DELAY_CYCLES >= (2 ** 20)) begin
            $error("pcr_power_reset: POR_DELAY_CYCLES out of range");
        end
    end

    ////////////////////////////////////////////////////////////////////
    // state
    pcr_state_t state;
    pcr_state_t next_state;
    logic [PC_FLAG_W-1:0] flags;
    logic [PC_FLAG_W-1:0] next_flags;
    logic idle;
    logic next_idle;
    logic stop;
    logic next_stop;
    logic mon_en;
    logic next_mon_en;
    logic mon_lvl;
    logic next_mon_lvl;
    logic mon_sel;
    logic next_mon_sel;
    logic por_flag;
    logic next_por_flag;
    logic by_monitor;
    logic next_by_monitor;
    logic [7:0] rdata;
    logic [7:0] next_rdata;
    logic boot;
    logic next_boot;
    logic wdt_en;
    logic next_wdt_en;
    logic [3:0] wdt_cnt;
    logic [3:0] next_wdt_cnt;
    logic wdt_tick;
    logic next_wdt_tick;
    logic delay_done;
    logic mon_trip;
    logic flash_err;
    logic trapped;
    logic other_src;
    logic wr_pc;
    logic wr_smc;
    logic wr_rc;
    logic running;

    pcr_delay_counter #(
        .CNT_W(20),
        .COUNT(POR_DELAY_CYCLES)
    ) u_por_delay (
        .clock_i(clock_i),
        .arst_n_i(arst_n_i),
        .run_i(state == ST_POR_DELAY),
        .done_o(delay_done)
    );

    ////////////////////////////////////////////////////////////////////
    // reset sources
    assign running = (state == ST_RUN);
    assign mon_trip = mon_en && mon_sel && !supply_above_i;
    assign flash_err = flash_op_i && !(mon_en && mon_lvl);
    // uncalibrated regulator sits under the high threshold, so a
    // non-power-on reset with high level never clears by itself
    assign trapped = mon_en && mon_lvl;
    assign other_src = sw_reset_i || wdt_reset_i || flash_err;
    assign wr_pc = running && sfr_wr_i && (sfr_addr_i == PWR_CTRL_ADDR);
    assign wr_smc = running && sfr_wr_i &&
        (sfr_addr_i == SUP_MON_CTRL_ADDR);
    assign wr_rc = running && sfr_wr_i && (sfr_addr_i == RST_CAUSE_ADDR);

    always_comb begin
        next_state = state;
        next_by_monitor = by_monitor;
        next_por_flag = por_flag;
        next_boot = 1'b0;
        unique case (state)
            ST_POR_HOLD: begin
                if (!power_on_i && supply_above_i) begin
                    next_state = ST_POR_DELAY;
                end
            end
            ST_POR_DELAY: begin
                if (power_on_i || !supply_above_i) begin
                    next_state = ST_POR_HOLD;
                end else if (delay_done) begin
                    next_state = ST_RUN;
                    next_por_flag = 1'b1;
                    next_boot = 1'b1;
                end
            end
            ST_RESET_HOLD: begin
                if (power_on_i) begin
                    next_state = ST_POR_HOLD;
                end else if (trapped) begin
                    next_by_monitor = 1'b1;
                end else if (!mon_trip) begin
                    next_state = ST_RUN;
                    next_por_flag = 1'b0;
                    next_boot = 1'b1;
                end
            end
            ST_RUN: begin
                if (power_on_i) begin
                    next_state = ST_POR_HOLD;
                end else if (mon_trip || other_src) begin
                    next_state = ST_RESET_HOLD;
                    next_by_monitor = mon_trip;
                end
            end
        endcase
        if (next_state == ST_POR_HOLD) begin
            next_by_monitor = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // registers
    always_comb begin
        next_flags = flags;
        next_idle = idle;
        next_stop = stop;
        next_mon_en = mon_en;
        next_mon_lvl = mon_lvl;
        next_mon_sel = mon_sel;
        if (wr_pc) begin
            next_flags = sfr_wdata_i[PC_FLAG_LSB +: PC_FLAG_W];
            if (sfr_wdata_i[PC_STOP_BIT]) begin
                next_stop = 1'b1;
            end
        end
        // a write setting idle beats a coincident interrupt
        if (wr_pc && sfr_wdata_i[PC_IDLE_BIT]) begin
            next_idle = 1'b1;
        end else if (irq_pending_i) begin
            next_idle = 1'b0;
        end
        if (wr_smc) begin
            next_mon_en = sfr_wdata_i[SMC_EN_BIT];
            next_mon_lvl = sfr_wdata_i[SMC_LVL_BIT];
        end
        if (wr_rc) begin
            next_mon_sel = sfr_wdata_i[RC_POR_BIT];
        end
        if (!running) begin
            // flags and mode bits reload; memory is not touched here
            next_flags = FLAGS_RESET;
            next_idle = 1'b0;
            next_stop = 1'b0;
        end
        if (state == ST_POR_HOLD) begin
            next_mon_en = 1'b1;
            next_mon_sel = 1'b1;
            next_mon_lvl = 1'b0;
        end
    end

    always_comb begin
        next_rdata = RDATA_ZERO;
        if (sfr_rd_i) begin
            if (sfr_addr_i == PWR_CTRL_ADDR) begin
                // mode select bits always read back as zero
                next_rdata[PC_FLAG_LSB +: PC_FLAG_W] = flags;
            end else if (sfr_addr_i == SUP_MON_CTRL_ADDR) begin
                next_rdata[SMC_EN_BIT] = mon_en;
                next_rdata[SMC_STAT_BIT] = supply_above_i;
                next_rdata[SMC_LVL_BIT] = mon_lvl;
            end else if (sfr_addr_i == RST_CAUSE_ADDR) begin
                next_rdata[RC_POR_BIT] = por_flag;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // watchdog clock
    always_comb begin
        next_wdt_en = wdt_en;
        next_wdt_cnt = wdt_cnt;
        next_wdt_tick = 1'b0;
        if (!running) begin
            next_wdt_en = 1'b0;
            next_wdt_cnt = '0;
        end else begin
            if (boot) begin
                next_wdt_en = 1'b1;
            end else if (wdt_disable_i) begin
                next_wdt_en = 1'b0;
            end
            if (wdt_en && !stop) begin
                if (wdt_cnt == WDT_DIV - 4'h1) begin
                    next_wdt_cnt = '0;
                    next_wdt_tick = 1'b1;
                end else begin
                    next_wdt_cnt = wdt_cnt + 4'h1;
                end
            end
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state <= ST_POR_HOLD;
            flags <= FLAGS_RESET;
            idle <= 1'b0;
            stop <= 1'b0;
            mon_en <= 1'b1;
            mon_lvl <= 1'b0;
            mon_sel <= 1'b1;
            por_flag <= 1'b0;
            by_monitor <= 1'b0;
            rdata <= RDATA_ZERO;
            boot <= 1'b0;
            wdt_en <= 1'b0;
            wdt_cnt <= '0;
            wdt_tick <= 1'b0;
        end else begin
            state <= next_state;
            flags <= next_flags;
            idle <= next_idle;
            stop <= next_stop;
            mon_en <= next_mon_en;
            mon_lvl <= next_mon_lvl;
            mon_sel <= next_mon_sel;
            por_flag <= next_por_flag;
            by_monitor <= next_by_monitor;
            rdata <= next_rdata;
            boot <= next_boot;
            wdt_en <= next_wdt_en;
            wdt_cnt <= next_wdt_cnt;
            wdt_tick <= next_wdt_tick;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // registered outputs
    logic in_reset;
    logic pin_drive;
    logic cpu_en;
    logic periph_en;
    assign in_reset = (next_state != ST_RUN);
    // pin driven for power-on and monitor holds only
    assign pin_drive = (next_state == ST_POR_HOLD) ||
        (next_state == ST_POR_DELAY) ||
        ((next_state == ST_RESET_HOLD) && next_by_monitor);
    assign cpu_en = !in_reset && !next_idle && !next_stop;
    assign periph_en = !in_reset && !next_stop;

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            core_reset_o <= 1'b1;
            rst_pin_oe_o <= 1'b1;
            cpu_clk_en_o <= 1'b0;
            periph_clk_en_o <= 1'b0;
            osc_stop_o <= 1'b0;
            clk_sel_internal_o <= 1'b1;
            port_force_o <= 1'b1;
        end else begin
            core_reset_o <= in_reset;
            rst_pin_oe_o <= pin_drive;
            cpu_clk_en_o <= cpu_en;
            periph_clk_en_o <= periph_en;
            osc_stop_o <= next_stop;
            clk_sel_internal_o <= in_reset || next_boot;
            port_force_o <= in_reset;
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_pin_o <= 1'b0;
            port_latch_o <= PORT_LATCH_RESET;
            weak_pullup_en_o <= 1'b1;
            fetch_addr_o <= RESET_VECTOR;
        end else begin
            rst_pin_o <= 1'b0;
            port_latch_o <= PORT_LATCH_RESET;
            weak_pullup_en_o <= 1'b1;
            fetch_addr_o <= RESET_VECTOR;
        end
    end

    assign sfr_rdata_o = rdata;
    assign boot_o = boot;
    assign wdt_enable_o = wdt_en;
    assign wdt_tick_o = wdt_tick;
endmodule // pcr_power_reset

// >>> verification/pcr_power_reset_properties.sv
`timescale 1ns/10ps
module pcr_power_reset_checker #(
    parameter int POR_DELAY_CYCLES = 4
) (
    input wire logic clock_i, // clock
    input wire logic arst_n_i, // reset
    input wire logic [7:0] sfr_addr_i, // address
    input wire logic [7:0] sfr_wdata_i, // write data
    input wire logic sfr_wr_i, // write
    input wire logic sfr_rd_i, // read
    input wire logic [7:0] sfr_rdata_o, // read data
    input wire logic power_on_i, // power bad
    input wire logic irq_pending_i, // interrupt
    input wire logic wdt_disable_i, // wdt off
    input wire logic rst_pin_o, // pin level
    input wire logic rst_pin_oe_o, // pin driven
    input wire logic core_reset_o, // core reset
    input wire logic boot_o, // exit pulse
    input wire logic [15:0] fetch_addr_o, // vector
    input wire logic clk_sel_internal_o, // osc select
    input wire logic cpu_clk_en_o, // cpu clock
    input wire logic periph_clk_en_o, // periph clock
    input wire logic osc_stop_o, // osc halted
    input wire logic port_force_o, // ports forced
    input wire logic [7:0] port_latch_o, // latch value
    input wire logic weak_pullup_en_o, // pull-ups
    input wire logic wdt_enable_o, // wdt on
    input wire logic wdt_tick_o // wdt clock
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!arst_n_i);
    logic pc_wr;
    assign pc_wr = sfr_wr_i && sfr_addr_i == 8'h87 && !core_reset_o;
    idle_gates_cpu_a: assert property (
        pc_wr && sfr_wdata_i[1:0] == 2'b01 |=>
        !cpu_clk_en_o && (periph_clk_en_o || core_reset_o))
        else $error("idle write left cpu clock running");
    stop_halts_osc_a: assert property (
        pc_wr && sfr_wdata_i[1] |=>
        core_reset_o || (osc_stop_o && !periph_clk_en_o))
        else $error("stop write did not halt oscillator");
    mode_bits_zero_a: assert property (
        sfr_rd_i && sfr_addr_i == 8'h87 |=> sfr_rdata_o[1:0] == 2'b00)
        else $error("mode bits read nonzero");
    ports_in_reset_a: assert property (
        core_reset_o |-> port_force_o && port_latch_o == 8'hFF &&
        weak_pullup_en_o && !cpu_clk_en_o)
        else $error("ports not forced during reset");
    por_drives_pin_a: assert property (
        power_on_i |=> core_reset_o && rst_pin_oe_o && rst_pin_o == 1'b0)
        else $error("power-on did not drive pin");
    exit_boot_a: assert property (
        $fell(core_reset_o) |->
        boot_o && fetch_addr_o == 16'h0000 && clk_sel_internal_o)
        else $error("reset exit without boot state");
    boot_wdt_a: assert property (
        boot_o && !wdt_disable_i |=> wdt_enable_o || core_reset_o)
        else $error("watchdog not enabled at boot");
    tick_spacing_a: assert property (
        wdt_tick_o |=> !wdt_tick_o [*8])
        else $error("watchdog ticks too close");
    idle_wake_a: assert property (
        !cpu_clk_en_o && periph_clk_en_o && irq_pending_i && !sfr_wr_i
        |=> cpu_clk_en_o || core_reset_o)
        else $error("interrupt did not end idle");
endmodule // pcr_power_reset_checker

bind pcr_power_reset pcr_power_reset_checker #(
    .POR_DELAY_CYCLES(POR_DELAY_CYCLES)
) chk_i (
    .clock_i(clock_i), .arst_n_i(arst_n_i), .sfr_addr_i(sfr_addr_i),
    .sfr_wdata_i(sfr_wdata_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
    .sfr_rdata_o(sfr_rdata_o), .power_on_i(power_on_i),
    .irq_pending_i(irq_pending_i), .wdt_disable_i(wdt_disable_i),
    .rst_pin_o(rst_pin_o), .rst_pin_oe_o(rst_pin_oe_o),
    .core_reset_o(core_reset_o), .boot_o(boot_o),
    .fetch_addr_o(fetch_addr_o), .clk_sel_internal_o(clk_sel_internal_o),
    .cpu_clk_en_o(cpu_clk_en_o), .periph_clk_en_o(periph_clk_en_o),
    .osc_stop_o(osc_stop_o), .port_force_o(port_force_o),
    .port_latch_o(port_latch_o), .weak_pullup_en_o(weak_pullup_en_o),
    .wdt_enable_o(wdt_enable_o), .wdt_tick_o(wdt_tick_o));

// >>> verification/pcr_reset_pin_model.sv
`timescale 1ns/10ps
module pcr_reset_pin_model (
    input wire logic pin_out_i, // level the block drives
    input wire logic pin_oe_i, // block drives the pin
    output logic pin_o // resolved pin level
);
    // board pull-up: a released line reads high, never the last value
    assign pin_o = pin_oe_i ? pin_out_i : 1'b1;
endmodule // pcr_reset_pin_model

// >>> verification/test_power_control_and_reset_sources.sv
`timescale 1ns/10ps
module test_power_control_and_reset_sources;
    import pcr_pkg::*;
    logic clock_i = 0, arst_n_i = 0, sfr_wr_i = 0, sfr_rd_i = 0;
    logic [7:0] sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, d, q;
    logic power_on_i = 1, supply_above_i = 1, flash_op_i = 0, sw_reset_i = 0;
    logic wdt_reset_i = 0, wdt_disable_i = 0, irq_pending_i = 0, rst_pin_i;
    logic rst_pin_o, rst_pin_oe_o, core_reset_o, boot_o, clk_sel_internal_o;
    logic cpu_clk_en_o, periph_clk_en_o, osc_stop_o, port_force_o;
    logic weak_pullup_en_o, wdt_enable_o, wdt_tick_o;
    logic [7:0] sfr_rdata_o, port_latch_o;
    logic [15:0] fetch_addr_o;
    int err_count = 0, compares = 0, n, k;
    pcr_power_reset #(.POR_DELAY_CYCLES(4)) uut (
        .clock_i(clock_i), .arst_n_i(arst_n_i), .sfr_addr_i(sfr_addr_i),
        .sfr_wdata_i(sfr_wdata_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
        .sfr_rdata_o(sfr_rdata_o), .power_on_i(power_on_i),
        .supply_above_i(supply_above_i), .flash_op_i(flash_op_i),
        .sw_reset_i(sw_reset_i), .wdt_reset_i(wdt_reset_i),
        .wdt_disable_i(wdt_disable_i), .irq_pending_i(irq_pending_i),
        .rst_pin_i(rst_pin_i), .rst_pin_o(rst_pin_o),
        .rst_pin_oe_o(rst_pin_oe_o), .core_reset_o(core_reset_o),
        .boot_o(boot_o), .fetch_addr_o(fetch_addr_o),
        .clk_sel_internal_o(clk_sel_internal_o), .cpu_clk_en_o(cpu_clk_en_o),
        .periph_clk_en_o(periph_clk_en_o), .osc_stop_o(osc_stop_o),
        .port_force_o(port_force_o), .port_latch_o(port_latch_o),
        .weak_pullup_en_o(weak_pullup_en_o), .wdt_enable_o(wdt_enable_o),
        .wdt_tick_o(wdt_tick_o));
    pcr_reset_pin_model pin_i (
        .pin_out_i(rst_pin_o), .pin_oe_i(rst_pin_oe_o), .pin_o(rst_pin_i));
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] exp_flags(input logic [7:0] v);
        return {v[7:2], 2'b00};
    endfunction
    function automatic int exp_ticks(input int c);
        return c / 12;
    endfunction
    task automatic wrap_up;
        if (err_count == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, v);
        @(posedge clock_i);
        sfr_addr_i <= a;
        sfr_wdata_i <= v;
        sfr_wr_i <= 1'b1;
        @(posedge clock_i);
        sfr_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clock_i);
        sfr_addr_i <= a;
        sfr_rd_i <= 1'b1;
        @(posedge clock_i);
        sfr_rd_i <= 1'b0;
        @(negedge clock_i);
        v = sfr_rdata_o;
    endtask
    // one-cycle pulse: 0 sw reset, 1 watchdog, 2 flash op, 3 interrupt
    task automatic pulse(input int w);
        @(posedge clock_i);
        case (w)
            0: sw_reset_i <= 1'b1;
            1: wdt_reset_i <= 1'b1;
            2: flash_op_i <= 1'b1;
            default: irq_pending_i <= 1'b1;
        endcase
        @(posedge clock_i);
        {sw_reset_i, wdt_reset_i, flash_op_i, irq_pending_i} <= 4'h0;
        @(negedge clock_i);
    endtask
    task automatic supply(input logic v);
        @(posedge clock_i);
        supply_above_i <= v;
        repeat (3) @(negedge clock_i);
    endtask
    // bounded wait, so a stuck reset cannot hang the run
    task automatic wait_run(output int cyc);
        cyc = 0;
        do begin
            @(negedge clock_i);
            cyc++;
        end while (core_reset_o !== 1'b0 && cyc < 200);
        chk("run limit", cyc < 200, 1'b1);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        forever #4 clock_i = ~clock_i;
    end
    initial begin
        repeat (20000) @(posedge clock_i);
        err_count++;
        wrap_up();
    end
    initial begin
        k = $urandom(51);
        repeat (3) @(posedge clock_i);
        arst_n_i <= 1'b1;
        repeat (4) @(negedge clock_i);
        chk("por hold", core_reset_o, 1'b1);
        chk("por pin", rst_pin_i, 1'b0);
        chk("latch", port_latch_o, 8'hFF);
        chk("pullup", weak_pullup_en_o, 1'b1);
        chk("force", port_force_o, 1'b1);
        @(posedge clock_i);
        power_on_i <= 1'b0;
        wait_run(n);
        chk("por delay", n >= 4, 1'b1);
        chk("boot", boot_o, 1'b1);
        chk("vector", fetch_addr_o, 16'h0000);
        chk("clk sel", clk_sel_internal_o, 1'b1);
        chk("pin free", rst_pin_i, 1'b1);
        @(negedge clock_i);
        chk("wdt on", wdt_enable_o, 1'b1);
        rd(8'hEF, q);
        chk("por flag", q, 8'h02);
        rd(8'hFF, q);
        chk("monitor", q, 8'hC0);
        rd(8'h87, q);
        chk("power_control reset", q, 8'h00);
        rd(8'h3C, q);
        chk("unmapped", q, 8'h00);
        k = 0;
        repeat (120) begin
            @(negedge clock_i);
            k += wdt_tick_o;
        end
        chk("ticks", 16'(k), 16'(exp_ticks(120)));
        repeat (8) begin
            d = 8'($urandom);
            wr(8'h87, d & 8'hFC);
            rd(8'h87, q);
            chk("flags", q, exp_flags(d));
        end
        wr(8'h87, 8'h55);
        @(negedge clock_i);
        chk("idle cpu", cpu_clk_en_o, 1'b0);
        chk("idle periph", periph_clk_en_o, 1'b1);
        rd(8'h87, q);
        chk("idle read", q, exp_flags(8'h55));
        pulse(3);
        chk("wake", cpu_clk_en_o, 1'b1);
        wr(8'hFF, 8'h00);
        pulse(0);
        chk("sw reset", core_reset_o, 1'b1);
        chk("sw pin", rst_pin_i, 1'b1);
        wait_run(n);
        chk("sw exit", 16'(n), 16'h0001);
        rd(8'hEF, q);
        chk("por clear", q, 8'h00);
        rd(8'hFF, q);
        chk("mon kept off", q, 8'h40);
        rd(8'h87, q);
        chk("flags clear", q, 8'h00);
        supply(1'b0);
        chk("mon off", core_reset_o, 1'b0);
        supply(1'b1);
        wr(8'hEF, 8'h00);
        wr(8'hFF, 8'h80);
        supply(1'b0);
        chk("mon unselected", core_reset_o, 1'b0);
        supply(1'b1);
        wr(8'hEF, 8'h02);
        supply(1'b0);
        chk("trip", core_reset_o, 1'b1);
        chk("trip pin", rst_pin_i, 1'b0);
        @(posedge clock_i);
        supply_above_i <= 1'b1;
        wait_run(n);
        chk("mon exit", n < 4, 1'b1);
        rd(8'hEF, q);
        chk("por clear mon", q, 8'h00);
        pulse(2);
        chk("flash err", core_reset_o, 1'b1);
        chk("flash pin", rst_pin_i, 1'b1);
        wait_run(n);
        wr(8'hFF, 8'hA0);
        pulse(2);
        chk("flash ok", core_reset_o, 1'b0);
        wr(8'hFF, 8'h80);
        wr(8'hFF, 8'hA0);
        pulse(1);
        repeat (20) @(negedge clock_i);
        chk("trap", core_reset_o, 1'b1);
        chk("trap pin", rst_pin_i, 1'b0);
        @(posedge clock_i);
        power_on_i <= 1'b1;
        @(posedge clock_i);
        power_on_i <= 1'b0;
        wait_run(n);
        rd(8'hFF, q);
        chk("low level", q, 8'hC0);
        rd(8'hEF, q);
        chk("por set", q, 8'h02);
        wr(8'h87, 8'h02);
        @(negedge clock_i);
        chk("stop osc", osc_stop_o, 1'b1);
        chk("stop periph", periph_clk_en_o, 1'b0);
        pulse(3);
        chk("stop stays", osc_stop_o, 1'b1);
        pulse(0);
        wait_run(n);
        chk("stop exit", osc_stop_o, 1'b0);
        chk("stop boot", boot_o, 1'b1);
        @(posedge clock_i);
        wdt_disable_i <= 1'b1;
        @(posedge clock_i);
        wdt_disable_i <= 1'b0;
        @(negedge clock_i);
        chk("wdt off", wdt_enable_o, 1'b0);
        wrap_up();
    end
endmodule // test_power_control_and_reset_sources
